/* inc/mfsm_pkg.sv */
// Constants for the fault status mirror block of the hardware monitor.
// Assumes the register read port and event inputs share mclk.
//
// How it works
// - Voltage and fan channel limit errors set flags
// - Temperature interrupt or limit error sets flag
// - 12 V and core two limit errors set
// - Chassis intrusion going high sets bit four
// - External low on thermal pin sets bit
// - Diode short or open sets fault bits
// - Second mirror clears at power-on
// - First mirror clears at power-on
// - Mask bit one keeps flag off interrupt
package mfsm_pkg;
	localparam logic [7:0] MFSM_OFS_FLAGS_A = 8'h4C;
	localparam logic [7:0] MFSM_OFS_FLAGS_B = 8'h4D;
	localparam logic [7:0] MFSM_RST_FLAGS   = 8'h00;
	localparam logic [7:0] MFSM_B_RSVD_MASK = 8'h0C;
	localparam int         MFSM_A_TEMP_INT  = 4;
	localparam int         MFSM_A_TEMP_EXT  = 5;
	localparam int         MFSM_B_CHASSIS   = 4;
	localparam int         MFSM_B_THERMAL   = 5;
	localparam int         MFSM_B_DIODE_ONE = 6;
	localparam int         MFSM_B_DIODE_TWO = 7;
endpackage : mfsm_pkg

/* core/mfsm_status_mirror.sv */
// Two read-only status mirrors with their masked interrupt request.
// Assumes event inputs come from the limit and fault logic of the monitor.
`timescale 1ns/1ns
module mfsm_status_mirror
	import mfsm_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic [7:0] limit_err_a,
	input  wire logic [1:0] temp_irq,
	input  wire logic [1:0] limit_err_b,
	input  wire logic       chassis_intrusion,
	input  wire logic       thermal_alarm_pin_i,
	input  wire logic       thermal_alarm_pin_oe,
	input  wire logic       first_diode_fault,
	input  wire logic       second_diode_fault,
	input  wire logic [7:0] mask_a,
	input  wire logic [7:0] mask_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_rd,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            int_req
);

////////////////////////////////////////////////////////////////////////////////
	logic [7:0] flags_a_q;
	logic [7:0] flags_b_q;
	logic [7:0] rdata_q;
	logic       int_q;
	logic       chassis_q;
	wire  [7:0] set_a;
	wire  [7:0] set_b;
	wire  [7:0] flags_b_d;
	wire        thermal_alarm_pin_ext_low;
	wire        chassis_rise;
	wire  [7:0] rd_mux;
	wire        int_d;
	wire        hit_a;
	wire        hit_b;

	// Address match, shared by the read path and its checks.
	function automatic logic mfsm_hit(input logic [7:0] addr,
		input logic [7:0] ofs);
		return addr == ofs;
	endfunction

	assign set_a[3:0] = limit_err_a[3:0];
	assign set_a[7:6] = limit_err_a[7:6];
	assign set_a[MFSM_A_TEMP_INT] = limit_err_a[MFSM_A_TEMP_INT] | temp_irq[0];
	assign set_a[MFSM_A_TEMP_EXT] = limit_err_a[MFSM_A_TEMP_EXT] | temp_irq[1];

	assign set_b[1:0] = limit_err_b;
	assign set_b[3:2] = 2'h0;
	assign chassis_rise = chassis_intrusion & ~chassis_q;
	assign set_b[MFSM_B_CHASSIS] = chassis_rise;
	// external thermal pull
	// A low seen while we drive the pin ourselves is not an external event.
	assign thermal_alarm_pin_ext_low = ~thermal_alarm_pin_i & ~thermal_alarm_pin_oe;
	assign set_b[MFSM_B_THERMAL] = thermal_alarm_pin_ext_low;
	assign set_b[MFSM_B_DIODE_ONE] = first_diode_fault;
	assign set_b[MFSM_B_DIODE_TWO] = second_diode_fault;

	assign flags_b_d = (flags_b_q | set_b) & ~MFSM_B_RSVD_MASK;

	assign hit_a  = mfsm_hit(reg_addr, MFSM_OFS_FLAGS_A);
	assign hit_b  = mfsm_hit(reg_addr, MFSM_OFS_FLAGS_B);
	assign rd_mux = hit_a ? flags_a_q :
	                hit_b ? flags_b_q : 8'h00;

	assign int_d = |(flags_a_q & ~mask_a) | |(flags_b_q & ~mask_b);

////////////////////////////////////////////////////////////////////////////////
	// Flags are sticky; only resetn clears them, and register writes are ignored.
	// first mirror reset
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_a_q <= MFSM_RST_FLAGS;
		end else begin
			flags_a_q <= flags_a_q | set_a;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_b_q <= MFSM_RST_FLAGS;
			chassis_q <= 1'b0;
		end else begin
			flags_b_q <= flags_b_d;
			chassis_q <= chassis_intrusion;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= MFSM_RST_FLAGS;
			int_q   <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : rdata_q;
			int_q   <= int_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign int_req   = int_q;

////////////////////////////////////////////////////////////////////////////////
	AST_LIMIT_A: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_a[0] |=> flags_a_q[0]) else $error("limit flag a0 not set");
	AST_TEMP_IRQ: assert property (@(posedge mclk) disable iff (!resetn)
		temp_irq[1] |=> flags_a_q[MFSM_A_TEMP_EXT])
		else $error("temp irq flag not set");
	AST_LIMIT_B: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_b[1] |=> flags_b_q[1]) else $error("limit flag b1 not set");
	AST_CHASSIS: assert property (@(posedge mclk) disable iff (!resetn)
		$rose(chassis_intrusion) |=> flags_b_q[MFSM_B_CHASSIS])
		else $error("chassis flag not set");
	AST_THERMAL_ALARM_PIN: assert property (@(posedge mclk) disable iff (!resetn)
		(!thermal_alarm_pin_i && !thermal_alarm_pin_oe)
		|=> flags_b_q[MFSM_B_THERMAL]) else $error("thermal flag not set");
	AST_DIODE: assert property (@(posedge mclk) disable iff (!resetn)
		second_diode_fault |=> flags_b_q[MFSM_B_DIODE_TWO])
		else $error("diode flag not set");
	AST_RESET_B: assert property (@(posedge mclk)
		$rose(resetn) |-> flags_b_q == MFSM_RST_FLAGS)
		else $error("mirror b not clear after reset");
	AST_RESET_A: assert property (@(posedge mclk)
		$rose(resetn) |-> flags_a_q == MFSM_RST_FLAGS)
		else $error("mirror a not clear after reset");
	AST_MASK: assert property (@(posedge mclk) disable iff (!resetn)
		(mask_a == 8'hFF && mask_b == 8'hFF) |=> !int_req)
		else $error("masked flags raised interrupt");
	AST_RSVD: assert property (@(posedge mclk) disable iff (!resetn)
		reg_rd && hit_b |=> reg_rdata[3:2] == 2'h0)
		else $error("reserved bits not zero");

	AST_TEMP_INT: assert property (@(posedge mclk) disable iff (!resetn)
		temp_irq[0] |=> flags_a_q[MFSM_A_TEMP_INT])
		else $error("internal temp flag not set");

	AST_LIMIT_TEMP: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_a[MFSM_A_TEMP_EXT] |=> flags_a_q[MFSM_A_TEMP_EXT])
		else $error("remote temp limit flag not set");

	AST_LIMIT_A7: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_a[7] |=> flags_a_q[7])
		else $error("limit flag a7 not set");

	AST_LIMIT_A3: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_a[3] |=> flags_a_q[3])
		else $error("limit flag a3 not set");

	AST_LIMIT_B0: assert property (@(posedge mclk) disable iff (!resetn)
		limit_err_b[0] |=> flags_b_q[0])
		else $error("limit flag b0 not set");

	AST_DIODE_ONE: assert property (@(posedge mclk) disable iff (!resetn)
		first_diode_fault |=> flags_b_q[MFSM_B_DIODE_ONE])
		else $error("first diode flag not set");

	// Our own drive on the pin must never look like an external pull.
	AST_THERMAL_ALARM_PIN_SELF: assert property (@(posedge mclk) disable iff (!resetn)
		(thermal_alarm_pin_oe && !flags_b_q[MFSM_B_THERMAL])
		|=> !flags_b_q[MFSM_B_THERMAL])
		else $error("self driven pin set thermal flag");

	AST_CHASSIS_LOW: assert property (@(posedge mclk) disable iff (!resetn)
		(!chassis_intrusion && !flags_b_q[MFSM_B_CHASSIS])
		|=> !flags_b_q[MFSM_B_CHASSIS])
		else $error("chassis flag set without intrusion");

	AST_STICKY_A: assert property (@(posedge mclk) disable iff (!resetn)
		($past(flags_a_q) & ~flags_a_q) == 8'h00)
		else $error("mirror a flag fell without reset");

	AST_STICKY_B: assert property (@(posedge mclk) disable iff (!resetn)
		($past(flags_b_q) & ~flags_b_q) == 8'h00)
		else $error("mirror b flag fell without reset");

	AST_RSVD_B: assert property (@(posedge mclk) disable iff (!resetn)
		flags_b_q[3:2] == 2'h0)
		else $error("reserved mirror b bits set");

	AST_WR_IGNORED: assert property (@(posedge mclk) disable iff (!resetn)
		(reg_wr && set_a == 8'h00 && set_b == 8'h00)
		|=> ($stable(flags_a_q) && $stable(flags_b_q)))
		else $error("write changed a mirror");

	AST_READ_A: assert property (@(posedge mclk) disable iff (!resetn)
		(reg_rd && hit_a) |=> reg_rdata == $past(flags_a_q))
		else $error("mirror a read data wrong");

	AST_READ_B: assert property (@(posedge mclk) disable iff (!resetn)
		(reg_rd && hit_b) |=> reg_rdata == $past(flags_b_q))
		else $error("mirror b read data wrong");

	AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!resetn)
		(reg_rd && !hit_a && !hit_b) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");

	AST_RDATA_HOLD: assert property (@(posedge mclk) disable iff (!resetn)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");

	AST_INT_SET: assert property (@(posedge mclk) disable iff (!resetn)
		(|(flags_a_q & ~mask_a) || |(flags_b_q & ~mask_b)) |=> int_req)
		else $error("unmasked flag gave no interrupt");

	AST_INT_CLR: assert property (@(posedge mclk) disable iff (!resetn)
		((flags_a_q & ~mask_a) == 8'h00 && (flags_b_q & ~mask_b) == 8'h00)
		|=> !int_req)
		else $error("interrupt without unmasked flag");
endmodule // mfsm_status_mirror

/* test/mfsm_host.sv */
// Host model issuing register reads and writes.
// Assumes requests are taken at rising mclk edges.
`timescale 1ns/1ns
module mfsm_host (
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic            reg_rd,
	output logic            reg_wr
);
	initial {reg_addr, reg_rd, reg_wr} = '0;
	task automatic xfer(logic [7:0] a, bit w, output logic [7:0] d);
		@(posedge mclk) {reg_addr, reg_rd, reg_wr} <= {a, !w, w};
		@(posedge mclk) {reg_addr, reg_rd, reg_wr} <= {~a, 2'h0};
		@(posedge mclk) d = reg_rdata;
	endtask
endmodule // mfsm_host

/* test/mfsm_status_mirror_test.sv */
// Bench for the status mirror behind a host model.
// Assumes flags clear only by reset.
`timescale 1ns/1ns
module mfsm_status_mirror_test import mfsm_pkg::*; ;
	logic [7:0] limit_err_a = '0, mask_a = '0, mask_b = '0, d;
	logic [7:0] reg_addr, reg_rdata, reg_wdata = 8'hFF;
	logic [1:0] temp_irq = '0, limit_err_b = '0;
	logic mclk = '0, resetn = '0, thermal_alarm_pin_i = '1;
	logic reg_rd, reg_wr, int_req, thermal_alarm_pin_oe = '0;
	logic first_diode_fault = '0, second_diode_fault = '0;
	logic chassis_intrusion = '0;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	always #50 mclk = ~mclk;
	mfsm_status_mirror i_mfsm_status_mirror (
		.mclk                 (mclk),
		.resetn               (resetn),
		.limit_err_a          (limit_err_a),
		.temp_irq             (temp_irq),
		.limit_err_b          (limit_err_b),
		.chassis_intrusion    (chassis_intrusion),
		.thermal_alarm_pin_i  (thermal_alarm_pin_i),
		.thermal_alarm_pin_oe (thermal_alarm_pin_oe),
		.first_diode_fault    (first_diode_fault),
		.second_diode_fault   (second_diode_fault),
		.mask_a               (mask_a),
		.mask_b               (mask_b),
		.reg_addr             (reg_addr),
		.reg_rd               (reg_rd),
		.reg_wr               (reg_wr),
		.reg_wdata            (reg_wdata),
		.reg_rdata            (reg_rdata),
		.int_req              (int_req)
	);
	mfsm_host i_mfsm_host (
		.mclk      (mclk),
		.reg_rdata (reg_rdata),
		.reg_addr  (reg_addr),
		.reg_rd    (reg_rd),
		.reg_wr    (reg_wr)
	);
	task automatic complete_run(bit to);
		error_cnt += to;
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(logic [7:0] a, e, bit irq);
		if (irq) d = {7'h00, int_req};
		else i_mfsm_host.xfer(a, 1'b0, d);
		cmp_count++;
		if (d !== e) error_cnt++;
		if (d !== e) $display("[FAIL] %0t got %h exp %h", $time, d, e);
	endtask
	task automatic do_reset;
		@(posedge mclk) resetn <= '0;
		repeat (4) @(posedge mclk);
		@(posedge mclk) resetn <= '1;
	endtask
	task automatic t_flags_a;
		do_reset;
		chk(MFSM_OFS_FLAGS_A, MFSM_RST_FLAGS, 1'b0);
		chk(MFSM_OFS_FLAGS_B, MFSM_RST_FLAGS, 1'b0);
		@(posedge mclk) {limit_err_a, temp_irq} <= 10'h33E;
		chk(MFSM_OFS_FLAGS_A, 8'hEF, 1'b0);
	endtask
	task automatic t_self_drive;
		do_reset;
		@(posedge mclk) {thermal_alarm_pin_oe, thermal_alarm_pin_i} <= 2'h2;
		repeat (3) @(posedge mclk);
		chk(MFSM_OFS_FLAGS_B, 8'h00, 1'b0);
		chk(8'h00, 8'h00, 1'b0);
		@(posedge mclk) {thermal_alarm_pin_oe, thermal_alarm_pin_i} <= 2'h1;
	endtask
	task automatic t_flags_b;
		do_reset;
		@(posedge mclk) {limit_err_b, chassis_intrusion} <= 3'h7;
		{first_diode_fault, second_diode_fault, thermal_alarm_pin_i} <= 3'h6;
		i_mfsm_host.xfer(MFSM_OFS_FLAGS_B, 1'b1, d);
		chk(MFSM_OFS_FLAGS_B, 8'hF3, 1'b0);
	endtask
	task automatic t_mask;
		do_reset;
		@(posedge mclk) {mask_a, mask_b, limit_err_a} <= 24'hFFFF01;
		repeat (4) @(posedge mclk);
		chk(8'h00, 8'h00, 1'b1);
		@(posedge mclk) mask_a <= 8'hFE;
		repeat (3) @(posedge mclk);
		chk(8'h00, 8'h01, 1'b1);
	endtask
	always @(posedge mclk) if (++cyc == 1000) complete_run(1'b1);
	initial begin
		t_flags_a;
		t_self_drive;
		t_flags_b;
		t_mask;
		complete_run(1'b0);
	end
endmodule // mfsm_status_mirror_test
